/* File: common/io_page0_pkg.sv */
// Constants for the page-zero I/O control register bank.
// Assumes a single core clock and the core's I/O-control access strobes.
package io_page0_pkg;
    localparam logic [3:0] ADDR_PORT5_CTRL = 4'h5;
    localparam logic [3:0] ADDR_PORT6_DIR = 4'h6;
    localparam logic [3:0] ADDR_PORT7_DIR = 4'h7;
    localparam logic [3:0] ADDR_PORT8_DIR = 4'h8;
    localparam logic [3:0] ADDR_RAM_ADDR = 4'h9;
    localparam logic [3:0] ADDR_RAM_DATA = 4'ha;
    localparam logic [3:0] ADDR_CNT1_PRESET = 4'hb;
    localparam logic [3:0] ADDR_CNT2_PRESET = 4'hc;
    localparam logic [3:0] ADDR_HPW_PRESET = 4'hd;
    localparam logic [3:0] ADDR_LPW_PRESET = 4'he;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hf;
    localparam logic [7:0] PORT5_CTRL_MASK = 8'hef;
    localparam logic [7:0] RAM_ADDR_MASK = 8'h7f;
    localparam logic [7:0] IRQ_MASK_MASK = 8'hfd;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int PORT5_DIR_LSB = 5;
    localparam int P8H_SEL_BIT = 3;
    localparam int P8L_SEL_BIT = 2;
    localparam int P7H_SEL_BIT = 1;
    localparam int P7L_SEL_BIT = 0;
    localparam int IRQ_PORT_CHANGE = 7;
    localparam int IRQ_LOW_PULSE = 6;
    localparam int IRQ_HIGH_PULSE = 5;
    localparam int IRQ_COUNTER_TWO = 4;
    localparam int IRQ_COUNTER_ONE = 3;
    localparam int IRQ_EXT_PIN = 2;
    localparam int IRQ_TICK = 0;
    localparam int RAM_DEPTH = 128;
endpackage

/* File: core/down_counter.sv */
// One 8-bit down-counter with a power-of-two prescaler and preset reload.
// Assumes count_en pulses once per source clock tick in the core domain.
`timescale 1ns/100ps
module down_counter
    import io_page0_pkg::*;
#(
    parameter int WIDTH = 8
)(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control.
    input wire logic run,
    input wire logic count_en,
    input wire logic [2:0] prescale_sel,
    input wire logic [WIDTH-1:0] preset,
    // Result.
    output logic underflow
);
    typedef struct packed {
        logic [7:0] pre;
        logic [WIDTH-1:0] cnt;
        logic uf;
    } cnt_state_t;

    cnt_state_t st_reg;
    cnt_state_t st_next;
    logic [7:0] pre_last;

    // Ratio is 2 at code 0 and doubles each step up to 256.
    assign pre_last = 8'((9'h2 << prescale_sel) - 9'h1);

    always_comb
    begin
        st_next = st_reg;
        st_next.uf = 1'b0;
        if (!run)
        begin
            st_next.pre = ZERO_BYTE;
            st_next.cnt = preset;
        end
        else if (count_en)
        begin
            if (st_reg.pre >= pre_last)
            begin
                st_next.pre = ZERO_BYTE;
                // Counting preset down to zero and then reloading gives preset+1 ticks.
                if (st_reg.cnt == '0)
                begin
                    st_next.cnt = preset;
                    st_next.uf = 1'b1;
                end
                else
                begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            end
            else
            begin
                st_next.pre = st_reg.pre + 8'h1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign underflow = st_reg.uf;
endmodule

/* File: core/io_control_page0_registers.sv */
// Page-zero I/O control register bank: directions, segment switches,
// RAM window, counter and pulse-timer presets, interrupt mask.
// Assumes the core presents synchronous I/O-control read and write strobes.
`timescale 1ns/100ps
module io_control_page0_registers
    import io_page0_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // I/O-control access from the core.
    input wire logic page_sel,
    input wire logic [3:0] ioc_addr,
    input wire logic ioc_wr,
    input wire logic ioc_rd,
    input wire logic [7:0] ioc_wdata,
    output logic [7:0] ioc_rdata,
    // Timer controls from the page-one bank.
    input wire logic [7:0] counter_prescale_control,
    input wire logic [7:0] pulse_timer_prescale_control,
    input wire logic fs_tick,
    input wire logic fm_tick,
    input wire logic counter_one_run,
    input wire logic counter_two_run,
    input wire logic pulse_run,
    input wire logic ir_enable,
    // Interrupt source events.
    input wire logic port_change_event,
    input wire logic ext_pin_event,
    input wire logic tick_overflow_event,
    // Pin control outputs.
    output logic [2:0] port_five_dir_bit,
    output logic [7:0] port_six_dir_bit,
    output logic [7:0] port_seven_dir_bit,
    output logic [7:0] port_eight_dir_bit,
    output logic port_eight_high_seg_sel,
    output logic port_eight_low_seg_sel,
    output logic port_seven_high_seg_sel,
    output logic port_seven_low_seg_sel,
    // Timer and interrupt results.
    output logic ir_out,
    output logic [7:0] irq_event,
    output logic [7:0] irq_enable
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic {PHASE_HIGH, PHASE_LOW} pulse_phase_t;

    typedef struct packed {
        logic [7:0] p5;
        logic [7:0] p6;
        logic [7:0] p7;
        logic [7:0] p8;
        logic [7:0] raddr;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] hp;
        logic [7:0] lp;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic carrier;
        pulse_phase_t phase;
        logic [7:0] ev;
    } bank_state_t;

    bank_state_t st_reg;
    bank_state_t st_next;
    logic [7:0] ram_mem [RAM_DEPTH];
    logic hit;
    logic wr_hit;
    logic c1_tick;
    logic c2_tick;
    logic hp_tick;
    logic lp_tick;
    logic c1_uf;
    logic c2_uf;
    logic hp_uf;
    logic lp_uf;

    ////////////////////////////////////////////////////////////////////////
    // Source select bits sit at 3 and 7 of each prescale control byte.
    assign hit = !page_sel && (ioc_addr >= ADDR_PORT5_CTRL);
    assign wr_hit = hit && ioc_wr;
    assign c1_tick = counter_prescale_control[3] ? fm_tick : fs_tick;
    assign c2_tick = counter_prescale_control[7] ? fm_tick : fs_tick;
    assign hp_tick = pulse_timer_prescale_control[3] ? fm_tick : fs_tick;
    assign lp_tick = pulse_timer_prescale_control[7] ? fm_tick : fs_tick;

    down_counter #(.WIDTH(8)) u_counter_one (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(counter_one_run),
        .count_en(c1_tick),
        .prescale_sel(counter_prescale_control[2:0]),
        .preset(st_reg.c1),
        .underflow(c1_uf)
    );

    down_counter #(.WIDTH(8)) u_counter_two (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(counter_two_run),
        .count_en(c2_tick),
        .prescale_sel(counter_prescale_control[6:4]),
        .preset(st_reg.c2),
        .underflow(c2_uf)
    );

    // A timer starts in the cycle its partner underflows, hiding the phase register's delay.
    down_counter #(.WIDTH(8)) u_high_pulse (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(pulse_run && (st_reg.phase == PHASE_HIGH || lp_uf)),
        .count_en(hp_tick),
        .prescale_sel(pulse_timer_prescale_control[2:0]),
        .preset(st_reg.hp),
        .underflow(hp_uf)
    );

    down_counter #(.WIDTH(8)) u_low_pulse (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(pulse_run && (st_reg.phase == PHASE_LOW || hp_uf)),
        .count_en(lp_tick),
        .prescale_sel(pulse_timer_prescale_control[6:4]),
        .preset(st_reg.lp),
        .underflow(lp_uf)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next = st_reg;
        st_next.ev = ZERO_BYTE;
        if (wr_hit)
        begin
            if (ioc_addr == ADDR_PORT5_CTRL)
            begin
                st_next.p5 = ioc_wdata & PORT5_CTRL_MASK;
            end
            else if (ioc_addr == ADDR_PORT6_DIR)
            begin
                st_next.p6 = ioc_wdata;
            end
            else if (ioc_addr == ADDR_PORT7_DIR)
            begin
                st_next.p7 = ioc_wdata;
            end
            else if (ioc_addr == ADDR_PORT8_DIR)
            begin
                st_next.p8 = ioc_wdata;
            end
            else if (ioc_addr == ADDR_RAM_ADDR)
            begin
                st_next.raddr = ioc_wdata & RAM_ADDR_MASK;
            end
            else if (ioc_addr == ADDR_CNT1_PRESET)
            begin
                st_next.c1 = ioc_wdata;
            end
            else if (ioc_addr == ADDR_CNT2_PRESET)
            begin
                st_next.c2 = ioc_wdata;
            end
            else if (ioc_addr == ADDR_HPW_PRESET)
            begin
                st_next.hp = ioc_wdata;
            end
            else if (ioc_addr == ADDR_LPW_PRESET)
            begin
                st_next.lp = ioc_wdata;
            end
            else if (ioc_addr == ADDR_IRQ_MASK)
            begin
                st_next.mask = ioc_wdata & IRQ_MASK_MASK;
            end
        end
        // Read data is registered; it shows one cycle after the read strobe.
        if (hit && ioc_rd)
        begin
            if (ioc_addr == ADDR_PORT5_CTRL)
            begin
                st_next.rdata = st_reg.p5;
            end
            else if (ioc_addr == ADDR_PORT6_DIR)
            begin
                st_next.rdata = st_reg.p6;
            end
            else if (ioc_addr == ADDR_PORT7_DIR)
            begin
                st_next.rdata = st_reg.p7;
            end
            else if (ioc_addr == ADDR_PORT8_DIR)
            begin
                st_next.rdata = st_reg.p8;
            end
            else if (ioc_addr == ADDR_RAM_ADDR)
            begin
                st_next.rdata = st_reg.raddr;
            end
            else if (ioc_addr == ADDR_RAM_DATA)
            begin
                st_next.rdata = ram_mem[st_reg.raddr[6:0]];
            end
            else if (ioc_addr == ADDR_CNT1_PRESET)
            begin
                st_next.rdata = st_reg.c1;
            end
            else if (ioc_addr == ADDR_CNT2_PRESET)
            begin
                st_next.rdata = st_reg.c2;
            end
            else if (ioc_addr == ADDR_HPW_PRESET)
            begin
                st_next.rdata = st_reg.hp;
            end
            else if (ioc_addr == ADDR_LPW_PRESET)
            begin
                st_next.rdata = st_reg.lp;
            end
            else
            begin
                st_next.rdata = st_reg.mask;
            end
        end
        else if (ioc_rd)
        begin
            st_next.rdata = ZERO_BYTE;
        end
        if (!ir_enable)
        begin
            st_next.carrier = 1'b0;
        end
        else if (c2_uf)
        begin
            st_next.carrier = !st_reg.carrier;
        end
        if (!pulse_run)
        begin
            st_next.phase = PHASE_HIGH;
        end
        else
        begin
            case (st_reg.phase)
                PHASE_HIGH:
                begin
                    if (hp_uf)
                    begin
                        st_next.phase = PHASE_LOW;
                    end
                end
                default:
                begin
                    if (lp_uf)
                    begin
                        st_next.phase = PHASE_HIGH;
                    end
                end
            endcase
        end
        st_next.ev[IRQ_PORT_CHANGE] = port_change_event;
        st_next.ev[IRQ_LOW_PULSE] = lp_uf;
        st_next.ev[IRQ_HIGH_PULSE] = hp_uf;
        st_next.ev[IRQ_COUNTER_TWO] = c2_uf;
        st_next.ev[IRQ_COUNTER_ONE] = c1_uf;
        st_next.ev[IRQ_EXT_PIN] = ext_pin_event;
        st_next.ev[IRQ_TICK] = tick_overflow_event;
    end

    // Directions reset to input so no pin drives before software decides.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.p5 <= DIR_RESET & PORT5_CTRL_MASK & 8'he0;
            st_reg.p6 <= DIR_RESET;
            st_reg.p7 <= DIR_RESET;
            st_reg.p8 <= DIR_RESET;
            st_reg.phase <= PHASE_HIGH;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // The RAM has no reset; its contents are undefined until written.
    always_ff @(posedge ref_clk)
    begin
        if (wr_hit && ioc_addr == ADDR_RAM_DATA)
        begin
            ram_mem[st_reg.raddr[6:0]] <= ioc_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign ioc_rdata = st_reg.rdata;
    assign port_five_dir_bit = st_reg.p5[7:PORT5_DIR_LSB];
    assign port_six_dir_bit = st_reg.p6;
    assign port_seven_dir_bit = st_reg.p7;
    assign port_eight_dir_bit = st_reg.p8;
    assign port_eight_high_seg_sel = st_reg.p5[P8H_SEL_BIT];
    assign port_eight_low_seg_sel = st_reg.p5[P8L_SEL_BIT];
    assign port_seven_high_seg_sel = st_reg.p5[P7H_SEL_BIT];
    assign port_seven_low_seg_sel = st_reg.p5[P7L_SEL_BIT];
    assign ir_out = ir_enable && (pulse_run ? (st_reg.phase == PHASE_HIGH && st_reg.carrier)
                                            : st_reg.carrier);
    assign irq_event = st_reg.ev;
    assign irq_enable = st_reg.mask;
endmodule

/* File: bench/io_page0_assertions.sv */
// Assertions on the page-zero bank ports: writes, refusals, read hold, events.
// Assumes it is bound to the bank below and sees only the bank's ports.
`timescale 1ns/100ps
module io_page0_checker
    import io_page0_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Access.
    input wire logic page_sel,
    input wire logic [3:0] ioc_addr,
    input wire logic ioc_wr,
    input wire logic ioc_rd,
    input wire logic [7:0] ioc_wdata,
    input wire logic [7:0] ioc_rdata,
    // Events and carrier.
    input wire logic port_change_event,
    input wire logic ext_pin_event,
    input wire logic tick_overflow_event,
    input wire logic ir_enable,
    input wire logic ir_out,
    // Results.
    input wire logic [2:0] port_five_dir_bit,
    input wire logic [7:0] port_six_dir_bit,
    input wire logic port_eight_high_seg_sel,
    input wire logic port_eight_low_seg_sel,
    input wire logic port_seven_high_seg_sel,
    input wire logic port_seven_low_seg_sel,
    input wire logic [7:0] irq_event,
    input wire logic [7:0] irq_enable
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Writes count only on page zero, since page one belongs to another bank.
    logic wr_ok;
    assign wr_ok = ioc_wr && !page_sel;
    ////////////////
    port5_write_a: assert property (
        wr_ok && ioc_addr == ADDR_PORT5_CTRL |=> {port_five_dir_bit, port_eight_high_seg_sel,
        port_eight_low_seg_sel, port_seven_high_seg_sel, port_seven_low_seg_sel}
        == {$past(ioc_wdata[7:5]), $past(ioc_wdata[3:0])})
        else $error("port five control write not applied");
    dir6_write_a: assert property (
        wr_ok && ioc_addr == ADDR_PORT6_DIR |=> port_six_dir_bit == $past(ioc_wdata))
        else $error("port six direction write not applied");
    mask_write_a: assert property (
        wr_ok && ioc_addr == ADDR_IRQ_MASK |=> irq_enable == ($past(ioc_wdata) & IRQ_MASK_MASK))
        else $error("mask write not applied");
    page_block_a: assert property (
        ioc_wr && page_sel |=> $stable(port_six_dir_bit) && $stable(irq_enable))
        else $error("write taken on page one");
    refused_read_a: assert property (
        ioc_rd && (page_sel || ioc_addr < 4'h5) |=> ioc_rdata == ZERO_BYTE)
        else $error("refused read returned data");
    rdata_hold_a: assert property (
        !ioc_rd |=> $stable(ioc_rdata))
        else $error("read data changed without a read");
    event_copy_a: assert property (
        (irq_event & 8'h85) == {$past(port_change_event), 4'h0, $past(ext_pin_event), 1'b0,
        $past(tick_overflow_event)})
        else $error("event not copied one cycle later");
    unused_bit_a: assert property (
        irq_event[1] == 1'b0 && irq_enable[1] == 1'b0)
        else $error("unused interrupt bit set");
    ir_off_a: assert property (
        !$past(ir_enable) |-> !ir_out)
        else $error("carrier out while disabled");
    cover property (wr_ok && ioc_addr == ADDR_RAM_DATA);
    cover property (ioc_rd && page_sel);
    cover property (irq_event[IRQ_COUNTER_TWO]);
endmodule
bind io_control_page0_registers io_page0_checker chk_u (.ref_clk, .rst_n, .page_sel, .ioc_addr,
    .ioc_wr, .ioc_rd, .ioc_wdata, .ioc_rdata, .port_change_event, .ext_pin_event,
    .tick_overflow_event, .ir_enable, .ir_out, .port_five_dir_bit, .port_six_dir_bit,
    .port_eight_high_seg_sel, .port_eight_low_seg_sel, .port_seven_high_seg_sel,
    .port_seven_low_seg_sel, .irq_event, .irq_enable);

/* File: bench/testbench.sv */
// Self-checking bench for the page-zero register bank.
// Assumes the package, the bank and its checker; this module drives every port.
`timescale 1ns/100ps
module testbench
    import io_page0_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic page_sel = 1'b0;
    logic [3:0] ioc_addr = 4'h0;
    logic ioc_wr = 1'b0;
    logic ioc_rd = 1'b0;
    logic [7:0] ioc_wdata = 8'h00;
    logic [7:0] cnt_ctl = 8'h00;
    logic [7:0] pw_ctl = 8'h00;
    logic c1_run = 1'b0;
    logic c2_run = 1'b0;
    logic p_run = 1'b0;
    logic ir_en = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [7:0] ioc_rdata, p6, p7, p8, irq_event, irq_enable, v, d, e;
    logic [2:0] p5;
    logic [3:0] lcd_segment_output;
    logic ir_out;
    logic [7:0] ra [4] = '{8'h00, 8'h7f, 8'h05, 8'h40};
    logic [7:0] evx [3] = '{8'h01, 8'h04, 8'h80};
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int a, n;
    ////////////////
    io_control_page0_registers dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .page_sel(page_sel),
        .ioc_addr(ioc_addr), .ioc_wr(ioc_wr), .ioc_rd(ioc_rd), .ioc_wdata(ioc_wdata),
        .ioc_rdata(ioc_rdata), .counter_prescale_control(cnt_ctl),
        .pulse_timer_prescale_control(pw_ctl), .fs_tick(1'b1), .fm_tick(1'b0),
        .counter_one_run(c1_run), .counter_two_run(c2_run), .pulse_run(p_run),
        .ir_enable(ir_en), .port_change_event(ev[2]), .ext_pin_event(ev[1]),
        .tick_overflow_event(ev[0]), .port_five_dir_bit(p5), .port_six_dir_bit(p6),
        .port_seven_dir_bit(p7), .port_eight_dir_bit(p8), .port_eight_high_seg_sel(lcd_segment_output[3]),
        .port_eight_low_seg_sel(lcd_segment_output[2]), .port_seven_high_seg_sel(lcd_segment_output[1]),
        .port_seven_low_seg_sel(lcd_segment_output[0]), .ir_out(ir_out), .irq_event(irq_event),
        .irq_enable(irq_enable));
    always #4 ref_clk = ~ref_clk;
    ////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Each access leaves one idle edge so a strobe is never lowered and raised at once.
    task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
        ioc_addr <= ad;
        ioc_wdata <= dt;
        ioc_wr <= 1'b1;
        @(posedge ref_clk);
        ioc_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] ad, output logic [7:0] dt);
        ioc_addr <= ad;
        ioc_rd <= 1'b1;
        @(posedge ref_clk);
        ioc_rd <= 1'b0;
        @(posedge ref_clk);
        dt = ioc_rdata;
    endtask
    task automatic gap(input int b1, input int b2, output int k);
        k = 0;
        while (irq_event[b1] !== 1'b1 && k < 2000)
        begin
            @(posedge ref_clk);
            k++;
        end
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (irq_event[b2] !== 1'b1 && k < 2000);
    endtask
    function automatic logic [7:0] msk(input logic [3:0] ad);
        msk = ad == ADDR_PORT5_CTRL ? PORT5_CTRL_MASK : ad == ADDR_RAM_ADDR ? RAM_ADDR_MASK :
            ad == ADDR_IRQ_MASK ? IRQ_MASK_MASK : 8'hff;
    endfunction
    function automatic logic [7:0] pins(input logic [3:0] ad, input logic [7:0] dflt);
        case (ad)
            ADDR_PORT5_CTRL: pins = {p5, 1'b0, lcd_segment_output};
            ADDR_PORT6_DIR: pins = p6;
            ADDR_PORT7_DIR: pins = p7;
            ADDR_PORT8_DIR: pins = p8;
            ADDR_IRQ_MASK: pins = irq_enable;
            default: pins = dflt;
        endcase
    endfunction
    task finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // The ceiling is several times the expected run, so only a hang reaches it.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            errors++;
            finish_test;
        end
    end
    ////////////////
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (a = 5; a < 16; a++)
            if (a != 10)
            begin
                e = a == 5 ? 8'he0 : a < 9 ? DIR_RESET : ZERO_BYTE;
                rd(a[3:0], v);
                chk("reset value", v, e);
                chk("reset pins", pins(a[3:0], v), e);
            end
        for (int p = 0; p < 2; p++)
            for (a = 5; a < 16; a++)
                if (a != 10)
                begin
                    d = p == 0 ? 8'ha5 : 8'h5a;
                    e = d & msk(a[3:0]);
                    wr(a[3:0], d);
                    rd(a[3:0], v);
                    chk("reg read", v, e);
                    chk("reg pins", pins(a[3:0], v), e);
                end
        page_sel <= 1'b1;
        wr(ADDR_PORT6_DIR, 8'h00);
        rd(ADDR_PORT6_DIR, v);
        chk("page one read", v, ZERO_BYTE);
        page_sel <= 1'b0;
        rd(ADDR_PORT6_DIR, v);
        chk("page one write", v, 8'h5a);
        rd(4'h4, v);
        chk("low address read", v, ZERO_BYTE);
        for (a = 0; a < 4; a++)
        begin
            wr(ADDR_RAM_ADDR, ra[a]);
            wr(ADDR_RAM_DATA, ra[a] ^ 8'hc3);
        end
        for (a = 0; a < 4; a++)
        begin
            wr(ADDR_RAM_ADDR, ra[a]);
            rd(ADDR_RAM_DATA, v);
            chk("ram byte", v, ra[a] ^ 8'hc3);
        end
        wr(ADDR_RAM_ADDR, 8'h85);
        rd(ADDR_RAM_DATA, v);
        chk("ram address top bit", v, 8'h05 ^ 8'hc3);
        // Counter 1 ratio 4 preset 2, counter 2 ratio 2 preset 3.
        cnt_ctl <= 8'h01;
        // High timer ratio 2 preset 1, low timer ratio 4 preset 2.
        pw_ctl <= 8'h10;
        wr(ADDR_CNT1_PRESET, 8'h02);
        wr(ADDR_CNT2_PRESET, 8'h03);
        wr(ADDR_HPW_PRESET, 8'h01);
        wr(ADDR_LPW_PRESET, 8'h02);
        c1_run <= 1'b1;
        c2_run <= 1'b1;
        p_run <= 1'b1;
        gap(IRQ_COUNTER_ONE, IRQ_COUNTER_ONE, n);
        chk("counter one period", n[7:0], 8'h0c);
        gap(IRQ_COUNTER_TWO, IRQ_COUNTER_TWO, n);
        chk("counter two period", n[7:0], 8'h08);
        gap(IRQ_HIGH_PULSE, IRQ_LOW_PULSE, n);
        chk("low phase", n[7:0], 8'h0c);
        gap(IRQ_LOW_PULSE, IRQ_HIGH_PULSE, n);
        chk("high phase", n[7:0], 8'h04);
        p_run <= 1'b0;
        ir_en <= 1'b1;
        n = 0;
        while (ir_out !== 1'b0 && n < 999)
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ir_out !== 1'b1 && n < 999)
        begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (ir_out === 1'b1 && n < 999)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("carrier half period", n[7:0], 8'h08);
        c1_run <= 1'b0;
        c2_run <= 1'b0;
        ir_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (a = 0; a < 3; a++)
        begin
            ev <= 3'h1 << a;
            @(posedge ref_clk);
            ev <= 3'h0;
            @(posedge ref_clk);
            chk("event flag", irq_event & 8'h85, evx[a]);
            @(posedge ref_clk);
            chk("event ends", irq_event & 8'h85, ZERO_BYTE);
        end
        finish_test;
    end
endmodule
